// file: rtl/ocinrush_pkg.sv
// package: register map, field layouts and constants for the start and inrush block
package ocinrush_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFF   = 8'h00;
   localparam logic [7:0] THR_OFF    = 8'h04;
   localparam logic [7:0] LIFT_OFF   = 8'h08;
   localparam logic [7:0] SEFTHR_OFF = 8'h0C;
   localparam logic [7:0] STAT_OFF   = 8'h10;
   localparam logic [7:0] IRQ_OFF    = 8'h14;
   localparam logic [7:0] MASK_OFF   = 8'h18;
   localparam logic [7:0] ELEM_OFF   = 8'h1C;

   // control field positions
   localparam int CTRL_RM_PH  = 0;
   localparam int CTRL_RM_GND = 1;
   localparam int CTRL_XBLK   = 2;
   localparam int CTRL_W      = 3;

   // per-element blocking type: bit0 phase oc, bit1 measured gnd, bit2 derived gnd,
   // bit3 sensitive gnd, bit4 negative sequence
   localparam int ELEM_W = 5;
   localparam int EL_POC = 0;
   localparam int EL_MEF = 1;
   localparam int EL_DEF = 2;
   localparam int EL_SEF = 3;
   localparam int EL_NPS = 4;

   // interrupt event bits
   localparam int EV_PH  = 0;
   localparam int EV_GND = 1;
   localparam int EV_HA  = 2;
   localparam int EV_SEF = 3;
   localparam int EV_W   = 4;

   // reset values
   localparam logic [CTRL_W-1:0] CTRL_RST   = 3'h0;
   localparam logic [ELEM_W-1:0] ELEM_RST   = 5'h1F;
   localparam logic [7:0]        THR_RST    = 8'h12;  // ratio in percent
   localparam logic [15:0]       LIFT_RST   = 16'hFFFF;
   localparam logic [7:0]        SEFTHR_RST = 8'h12;
   localparam logic [EV_W-1:0]   MASK_RST   = 4'h0;

   // current magnitude scale: 1 lsb = 1 mA
   localparam int          CUR_W        = 16;
   localparam logic [15:0] SEF_MIN_MA   = 16'h0004;  // 4 mA
   localparam logic [15:0] SEF_MAX_MA   = 16'h0708;  // 1800 mA
   localparam logic [15:0] LOW_CUR_MA   = 16'h0032;  // fixed low-current level
   localparam int          DROPOFF_CYC  = 1;         // power-system cycles

   // measured quantities for one current input, updated per power-system cycle
   typedef struct packed {
      logic [CUR_W-1:0] fund;    // fundamental rms
      logic [CUR_W-1:0] harm2;   // second harmonic rms
      logic [CUR_W-1:0] peak;    // largest sample over the previous cycle
   } meas_s;
endpackage

// file: rtl/harm_detect.sv
// module: second-harmonic ratio detector for one current input
`timescale 1ns/1ps
`default_nettype none
module harm_detect #(
   parameter int W = 16
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         sample,
   input  wire logic [W-1:0] fund,
   input  wire logic [W-1:0] harm2,
   input  wire logic [7:0]   thr_pct,
   input  wire logic [W-1:0] lift,
   input  wire logic [W-1:0] low_lvl,
   output logic              detect
);
   // ratio test without a divider: harm2*100 > fund*thr
   wire logic [W+7:0] harm_scaled = harm2 * (W+8)'(100);
   wire logic [W+7:0] fund_scaled = fund * (W+8)'(thr_pct);
   wire logic         ratio_high  = harm_scaled > fund_scaled;
   wire logic         lifted      = fund > lift;
   wire logic         enough      = fund > low_lvl;
   wire logic         det_next    = ratio_high & ~lifted & enough;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         detect <= 1'b0;
      end else if (sample) begin
         detect <= det_next;
      end
   end
endmodule // harm_detect
`default_nettype wire

// file: rtl/ocinrush_top.sv
// module: blocked start logic and second-harmonic inrush blocking with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module ocinrush_top #(
   parameter int STAGES = 4
) (
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // axi4-lite slave
   input  wire logic [7:0]            s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [7:0]            s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // per-cycle measurement strobe and quantities
   input  wire logic                  cycle_tick,
   input  wire ocinrush_pkg::meas_s   meas_a,
   input  wire ocinrush_pkg::meas_s   meas_b,
   input  wire ocinrush_pkg::meas_s   meas_c,
   input  wire ocinrush_pkg::meas_s   meas_sef,
   // stage starts, same clock domain
   input  wire logic [STAGES-1:0]     phase_start,
   input  wire logic [STAGES-1:0]     ground_start,
   input  wire logic [STAGES-1:0]     sef_start,
   input  wire logic                  breaker_fail_alarm,
   // outputs to contacts and protection elements
   output logic                       blocked_phase_start,
   output logic                       blocked_ground_start,
   output logic [STAGES-1:0]          phase_start_out,
   output logic [STAGES-1:0]          ground_start_out,
   output logic [STAGES-1:0]          sef_start_out,
   output logic                       phase_a_harmonic_block,
   output logic                       phase_b_harmonic_block,
   output logic                       phase_c_harmonic_block,
   output logic                       any_phase_harmonic_block,
   output logic                       sensitive_ground_harmonic_block,
   output logic [2:0]                 phase_oc_inhibit,
   output logic                       measured_ground_inhibit,
   output logic                       derived_ground_inhibit,
   output logic                       sensitive_ground_inhibit,
   output logic                       negative_sequence_inhibit,
   output logic                       irq
);
   localparam int CW = ocinrush_pkg::CUR_W;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [ocinrush_pkg::CTRL_W-1:0] ctrl_reg;
   logic [ocinrush_pkg::ELEM_W-1:0] elem_reg;
   logic [7:0]                      thr_reg;
   logic [CW-1:0]                   lift_reg;
   logic [7:0]                      sefthr_reg;
   logic [ocinrush_pkg::EV_W-1:0]   irq_reg;
   logic [ocinrush_pkg::EV_W-1:0]   mask_reg;
   logic [ocinrush_pkg::EV_W-1:0]   ev_prev_reg;
   logic                            sef_hold_reg;
   logic [1:0]                      drop_cnt_reg;

   // ------------------------------------------------------------
   // blocked start logic
   // ------------------------------------------------------------
   wire logic ph_or  = |phase_start;
   // ground start draws on the phase starts, as the scheme is documented
   wire logic gnd_or = |phase_start;
   wire logic bps_next = ph_or & ~(breaker_fail_alarm & ctrl_reg[ocinrush_pkg::CTRL_RM_PH]);
   wire logic bgs_next = gnd_or & ~(breaker_fail_alarm & ctrl_reg[ocinrush_pkg::CTRL_RM_GND]);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         blocked_phase_start  <= 1'b0;
         blocked_ground_start <= 1'b0;
         phase_start_out      <= '0;
         ground_start_out     <= '0;
         sef_start_out        <= '0;
      end else begin
         blocked_phase_start  <= bps_next;
         blocked_ground_start <= bgs_next;
         phase_start_out      <= phase_start;
         ground_start_out     <= ground_start;
         sef_start_out        <= sef_start;
      end
   end

   // ------------------------------------------------------------
   // phase harmonic detection
   // ------------------------------------------------------------
   logic [2:0] ph_det;
   wire ocinrush_pkg::meas_s ph_meas [3] = '{meas_a, meas_b, meas_c};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_phase
         // ratio, lift and low level tests
         harm_detect #(.W(CW)) u_det (
            .aclk    (aclk),
            .aresetn (aresetn),
            .sample  (cycle_tick),
            .fund    (ph_meas[gi].fund),
            .harm2   (ph_meas[gi].harm2),
            .thr_pct (thr_reg),
            .lift    (lift_reg),
            .low_lvl (ocinrush_pkg::LOW_CUR_MA),
            .detect  (ph_det[gi])
         );
      end
   endgenerate

   assign phase_a_harmonic_block   = ph_det[0];
   assign phase_b_harmonic_block   = ph_det[1];
   assign phase_c_harmonic_block   = ph_det[2];
   assign any_phase_harmonic_block = |ph_det;

   // ------------------------------------------------------------
   // sensitive ground harmonic detection
   // ------------------------------------------------------------
   logic sef_raw;
   // the 4 mA floor doubles as the low-current level here
   harm_detect #(.W(CW)) u_sef (
      .aclk    (aclk),
      .aresetn (aresetn),
      .sample  (cycle_tick),
      .fund    (meas_sef.fund),
      .harm2   (meas_sef.harm2),
      .thr_pct (sefthr_reg),
      .lift    (lift_reg),
      .low_lvl (ocinrush_pkg::SEF_MIN_MA - 16'h0001),
      .detect  (sef_raw)
   );

   // peak test registered on the same tick so it aligns with sef_raw
   logic sef_over_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sef_over_reg <= 1'b0;
      end else if (cycle_tick) begin
         sef_over_reg <= meas_sef.peak > ocinrush_pkg::SEF_MAX_MA;
      end
   end
   wire logic sef_cond = sef_raw & ~sef_over_reg;

   // instant pick-up, release held one tick after the condition clears
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         drop_cnt_reg <= 2'h0;
      end else if (sef_cond) begin
         drop_cnt_reg <= 2'(ocinrush_pkg::DROPOFF_CYC);
      end else if (cycle_tick && drop_cnt_reg != 2'h0) begin
         drop_cnt_reg <= drop_cnt_reg - 2'h1;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sef_hold_reg <= 1'b0;
      end else begin
         sef_hold_reg <= sef_cond | (drop_cnt_reg != 2'h0);
      end
   end
   // pick-up passes combinationally from the registered detector
   assign sensitive_ground_harmonic_block = sef_cond | sef_hold_reg;

   // ------------------------------------------------------------
   // element inhibit outputs
   // ------------------------------------------------------------
   wire logic       xblk      = ctrl_reg[ocinrush_pkg::CTRL_XBLK];
   wire logic       ph_en     = elem_reg[ocinrush_pkg::EL_POC];
   wire logic [2:0] ph_sel    = xblk ? {3{any_phase_harmonic_block}} : ph_det;
   // measured and derived ground elements follow the phase any-signal; sensitive ground follows its own block
   assign phase_oc_inhibit          = ph_sel & {3{ph_en}};
   assign measured_ground_inhibit   = elem_reg[ocinrush_pkg::EL_MEF] & any_phase_harmonic_block;
   assign derived_ground_inhibit    = elem_reg[ocinrush_pkg::EL_DEF] & any_phase_harmonic_block;
   assign sensitive_ground_inhibit  = elem_reg[ocinrush_pkg::EL_SEF] & sensitive_ground_harmonic_block;
   assign negative_sequence_inhibit = elem_reg[ocinrush_pkg::EL_NPS] & any_phase_harmonic_block;

   // ------------------------------------------------------------
   // interrupts
   // ------------------------------------------------------------
   wire logic [ocinrush_pkg::EV_W-1:0] ev_now = {sensitive_ground_harmonic_block, any_phase_harmonic_block,
                                                 blocked_ground_start, blocked_phase_start};
   wire logic [ocinrush_pkg::EV_W-1:0] ev_rise = ev_now & ~ev_prev_reg;
   assign irq = |(irq_reg & mask_reg);

   // ------------------------------------------------------------
   // axi4-lite slave
   // ------------------------------------------------------------
   logic        aw_got_reg;
   logic        w_got_reg;
   logic [7:0]  awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        rvalid_reg;
   logic [1:0]  rresp_reg;
   logic [31:0] rdata_reg;

   assign s_axi_awready = ~aw_got_reg & ~bvalid_reg;
   assign s_axi_wready  = ~w_got_reg & ~bvalid_reg;
   assign s_axi_arready = ~rvalid_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rresp   = rresp_reg;
   assign s_axi_rdata   = rdata_reg;

   wire logic        aw_take = s_axi_awvalid & s_axi_awready;
   wire logic        w_take  = s_axi_wvalid & s_axi_wready;
   wire logic        aw_have = aw_got_reg | aw_take;
   wire logic        w_have  = w_got_reg | w_take;
   wire logic        wr_go   = aw_have & w_have;
   wire logic [7:0]  wa      = aw_got_reg ? awaddr_reg : s_axi_awaddr;
   wire logic [31:0] wd      = w_got_reg ? wdata_reg : s_axi_wdata;
   wire logic [3:0]  ws      = w_got_reg ? wstrb_reg : s_axi_wstrb;

   wire logic wr_ctrl = wr_go & (wa == ocinrush_pkg::CTRL_OFF) & ws[0];
   wire logic wr_thr  = wr_go & (wa == ocinrush_pkg::THR_OFF) & ws[0];
   wire logic wr_lift = wr_go & (wa == ocinrush_pkg::LIFT_OFF);
   wire logic wr_sthr = wr_go & (wa == ocinrush_pkg::SEFTHR_OFF) & ws[0];
   wire logic wr_irq  = wr_go & (wa == ocinrush_pkg::IRQ_OFF) & ws[0];
   wire logic wr_mask = wr_go & (wa == ocinrush_pkg::MASK_OFF) & ws[0];
   wire logic wr_elem = wr_go & (wa == ocinrush_pkg::ELEM_OFF) & ws[0];
   wire logic wr_ok   = (wa == ocinrush_pkg::CTRL_OFF) | (wa == ocinrush_pkg::THR_OFF) |
                        (wa == ocinrush_pkg::LIFT_OFF) | (wa == ocinrush_pkg::SEFTHR_OFF) |
                        (wa == ocinrush_pkg::STAT_OFF) | (wa == ocinrush_pkg::IRQ_OFF) |
                        (wa == ocinrush_pkg::MASK_OFF) | (wa == ocinrush_pkg::ELEM_OFF);

   wire logic [CW-1:0] lift_next = {ws[1] ? wd[15:8] : lift_reg[15:8], ws[0] ? wd[7:0] : lift_reg[7:0]};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_reg <= 1'b0;
         w_got_reg  <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg  <= 32'h0000_0000;
         wstrb_reg  <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg  <= 2'h0;
      end else begin
         if (aw_take) awaddr_reg <= s_axi_awaddr;
         if (w_take) wdata_reg <= s_axi_wdata;
         if (w_take) wstrb_reg <= s_axi_wstrb;
         aw_got_reg <= aw_have & ~wr_go;
         w_got_reg  <= w_have & ~wr_go;
         if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_ok ? 2'h0 : 2'h2;
         end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg    <= ocinrush_pkg::CTRL_RST;
         elem_reg    <= ocinrush_pkg::ELEM_RST;
         thr_reg     <= ocinrush_pkg::THR_RST;
         lift_reg    <= ocinrush_pkg::LIFT_RST;
         sefthr_reg  <= ocinrush_pkg::SEFTHR_RST;
         mask_reg    <= ocinrush_pkg::MASK_RST;
         irq_reg     <= '0;
         ev_prev_reg <= '0;
      end else begin
         if (wr_ctrl) ctrl_reg <= wd[ocinrush_pkg::CTRL_W-1:0];
         if (wr_elem) elem_reg <= wd[ocinrush_pkg::ELEM_W-1:0];
         if (wr_thr) thr_reg <= wd[7:0];
         if (wr_lift) lift_reg <= lift_next;
         if (wr_sthr) sefthr_reg <= wd[7:0];
         if (wr_mask) mask_reg <= wd[ocinrush_pkg::EV_W-1:0];
         ev_prev_reg <= ev_now;
         // a new event wins over a same-cycle clear
         irq_reg <= (irq_reg & ~(wr_irq ? wd[ocinrush_pkg::EV_W-1:0] : '0)) | ev_rise;
      end
   end

   // read path
   wire logic [31:0] rd_mux =
      (s_axi_araddr == ocinrush_pkg::CTRL_OFF)   ? {29'h0, ctrl_reg} :
      (s_axi_araddr == ocinrush_pkg::THR_OFF)    ? {24'h0, thr_reg} :
      (s_axi_araddr == ocinrush_pkg::LIFT_OFF)   ? {16'h0, lift_reg} :
      (s_axi_araddr == ocinrush_pkg::SEFTHR_OFF) ? {24'h0, sefthr_reg} :
      (s_axi_araddr == ocinrush_pkg::STAT_OFF)   ? {24'h0, sensitive_ground_harmonic_block, ph_det,
                                                    any_phase_harmonic_block, blocked_ground_start,
                                                    blocked_phase_start, breaker_fail_alarm} :
      (s_axi_araddr == ocinrush_pkg::IRQ_OFF)    ? {28'h0, irq_reg} :
      (s_axi_araddr == ocinrush_pkg::MASK_OFF)   ? {28'h0, mask_reg} :
      (s_axi_araddr == ocinrush_pkg::ELEM_OFF)   ? {27'h0, elem_reg} : 32'h0000_0000;
   wire logic rd_ok = (s_axi_araddr <= ocinrush_pkg::ELEM_OFF) & (s_axi_araddr[1:0] == 2'h0);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rresp_reg  <= 2'h0;
         rdata_reg  <= 32'h0000_0000;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_reg <= 1'b1;
         rresp_reg  <= rd_ok ? 2'h0 : 2'h2;
         rdata_reg  <= rd_mux;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end
endmodule // ocinrush_top
`default_nettype wire

// file: verification/ocinrush_asserts.sv
// checker: port-level properties of the start and inrush block
`timescale 1ns/1ps
`default_nettype none
module ocinrush_asserts #(
   parameter int STAGES = 4
) (
   input wire logic                aclk,
   input wire logic                aresetn,
   input wire logic                cycle_tick,
   input wire ocinrush_pkg::meas_s meas_a,
   input wire ocinrush_pkg::meas_s meas_sef,
   input wire logic [STAGES-1:0]   phase_start,
   input wire logic                breaker_fail_alarm,
   input wire logic                blocked_phase_start,
   input wire logic                blocked_ground_start,
   input wire logic                phase_a_harmonic_block,
   input wire logic                any_phase_harmonic_block,
   input wire logic                sensitive_ground_harmonic_block,
   input wire logic [2:0]          phase_oc_inhibit,
   input wire logic                negative_sequence_inhibit
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   AST_PH_START: assert property (|phase_start && !breaker_fail_alarm |=> blocked_phase_start)
      else $error("phase start not passed");
   AST_PH_IDLE: assert property (!(|phase_start) |=> !blocked_phase_start && !blocked_ground_start)
      else $error("blocked start without stage start");
   AST_GND_START: assert property (|phase_start && !breaker_fail_alarm |=> blocked_ground_start)
      else $error("ground start not passed");
   AST_PH_HOLD: assert property (!$past(cycle_tick) |-> $stable(phase_a_harmonic_block))
      else $error("phase block moved without tick");
   AST_PH_LOW: assert property (cycle_tick && meas_a.fund <= 16'h0032 |=> !phase_a_harmonic_block)
      else $error("phase block at low current");
   AST_SEF_PICK: assert property ($rose(sensitive_ground_harmonic_block) |->
      $past(cycle_tick) && $past(meas_sef.fund) >= 16'h0004 && $past(meas_sef.peak) <= 16'h0708)
      else $error("sensitive block rose wrongly");
   AST_SEF_DROP: assert property ($fell(sensitive_ground_harmonic_block) |->
      $past(cycle_tick) || $past(cycle_tick, 2))
      else $error("sensitive block fell off tick");
   AST_INH_IDLE: assert property (!any_phase_harmonic_block |->
      phase_oc_inhibit == 3'h0 && !negative_sequence_inhibit)
      else $error("inhibit without harmonic block");
endmodule  // ocinrush_asserts

bind ocinrush_top ocinrush_asserts #(.STAGES(STAGES)) chk_u (
   .aclk(aclk), .aresetn(aresetn), .cycle_tick(cycle_tick), .meas_a(meas_a), .meas_sef(meas_sef),
   .phase_start(phase_start), .breaker_fail_alarm(breaker_fail_alarm), .blocked_phase_start(blocked_phase_start),
   .blocked_ground_start(blocked_ground_start), .phase_a_harmonic_block(phase_a_harmonic_block),
   .any_phase_harmonic_block(any_phase_harmonic_block),
   .sensitive_ground_harmonic_block(sensitive_ground_harmonic_block), .phase_oc_inhibit(phase_oc_inhibit),
   .negative_sequence_inhibit(negative_sequence_inhibit));
`default_nettype wire

// file: verification/relay_partner.sv
// model: a neighbouring relay whose stage timer is held by a blocking input
`timescale 1ns/1ps
`default_nettype none
module relay_partner #(
   parameter int TRIP_CYC = 20
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic fault,
   input  wire logic blocking_in,
   output logic      trip
);
   int count_reg;
   // a held timer keeps its count, so release resumes rather than restarts
   always_ff @(posedge aclk) begin
      if (!aresetn || !fault) begin
         count_reg <= 0;
         trip <= 1'b0;
      end else if (!blocking_in && count_reg < TRIP_CYC) begin
         count_reg <= count_reg + 1;
      end else if (count_reg == TRIP_CYC) begin
         trip <= 1'b1;
      end
   end
endmodule  // relay_partner
`default_nettype wire

// file: verification/tb_top.sv
// testbench: start gating, inrush blocking, registers and neighbour relays
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int S = 4;
   logic                aclk = 0, aresetn = 0, tick = 0, bfa = 0, flt = 0;
   logic [7:0]          awaddr = 0, araddr = 0;
   logic                awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0]         wdata = 0, rdata;
   logic [S-1:0]        ps = 0, gs = 0, ss = 0, pso, gso, sso;
   ocinrush_pkg::meas_s ma = 0, mb = 0, mc = 0, ms = 0;
   logic                awready, wready, bvalid, arready, rvalid, bps, bgs, ha, hb, hc, hany, hsef, irq, utr, btr;
   logic [1:0]          bresp, rresp;
   logic [2:0]          pinh, ginh;
   int                  miscompares = 0, samples_checked = 0, cyc = 0;

   ocinrush_top #(.STAGES(S)) dut_u (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .cycle_tick(tick), .meas_a(ma), .meas_b(mb), .meas_c(mc), .meas_sef(ms), .phase_start(ps), .ground_start(gs),
      .sef_start(ss), .breaker_fail_alarm(bfa), .blocked_phase_start(bps), .blocked_ground_start(bgs),
      .phase_start_out(pso), .ground_start_out(gso), .sef_start_out(sso), .phase_a_harmonic_block(ha),
      .phase_b_harmonic_block(hb), .phase_c_harmonic_block(hc), .any_phase_harmonic_block(hany),
      .sensitive_ground_harmonic_block(hsef), .phase_oc_inhibit(pinh), .measured_ground_inhibit(ginh[2]),
      .derived_ground_inhibit(ginh[1]), .sensitive_ground_inhibit(ginh[0]), .negative_sequence_inhibit(), .irq(irq));
   relay_partner #(.TRIP_CYC(20)) up_u (.aclk(aclk), .aresetn(aresetn), .fault(flt), .blocking_in(bps), .trip(utr));
   relay_partner #(.TRIP_CYC(3)) bus_u (.aclk(aclk), .aresetn(aresetn), .fault(flt), .blocking_in(bgs), .trip(btr));

   always #12.5 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 30000) begin
         miscompares++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chkb(input logic g, input logic e);
      chk({31'h0, g}, {31'h0, e});
   endtask
   // each channel is released at the edge that takes it, sampled 1 ns after the previous edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         #1 ta = awvalid & awready;
         tw = wvalid & wready;
         tb = bready & bvalid;
         @(posedge aclk);
         if (ta) awvalid <= 0;
         if (tw) wvalid <= 0;
         if (tb) bready <= 0;
      end while (!tb);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta, tr;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do begin
         #1 ta = arvalid & arready;
         tr = rready & rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 0;
         if (tr) rready <= 0;
      end while (!tr);
   endtask
   task automatic pulse(input ocinrush_pkg::meas_s a, b, c, s);
      @(posedge aclk);
      {ma, mb, mc, ms} <= {a, b, c, s};
      tick <= 1;
      @(posedge aclk);
      tick <= 0;
      repeat (2) @(posedge aclk);
      #1;
   endtask
   function automatic logic hexp(ocinrush_pkg::meas_s m, logic [7:0] t, logic [15:0] l, logic sensitive_ground_input);
      if (sensitive_ground_input) return m.fund >= 16'h0004 && m.peak <= 16'h0708 && m.fund <= l && 32'(m.harm2) * 100 > 32'(m.fund) * t;
      return m.fund > 16'h0032 && m.fund <= l && 32'(m.harm2) * 100 > 32'(m.fund) * t;
   endfunction
   function automatic ocinrush_pkg::meas_s rm();
      ocinrush_pkg::meas_s m;
      m.fund = 16'(20 + $urandom % 2000);
      m.harm2 = 16'($urandom % (m.fund / 2 + 1));
      m.peak = 16'(m.fund + $urandom % 400);
      return m;
   endfunction

   initial begin
      logic [31:0] d;
      logic [31:0] rv [9];
      logic [1:0] r;
      logic [7:0] thr;
      logic [15:0] lift;
      logic [2:0] ctl;
      logic ea, eb, ec, es, sp;
      ocinrush_pkg::meas_s va, vb, vc, vs;
      rv = '{32'h0, 32'h12, 32'hFFFF, 32'h12, 32'h0, 32'h0, 32'h0, 32'h1F, 32'h0};
      sp = 0;
      void'($urandom(25417));
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      for (int i = 0; i < 9; i++) begin
         rd(8'(i * 4), d, r);
         chk(d, rv[i]);
         chk({30'h0, r}, (i == 8) ? 32'h2 : 32'h0);
      end
      for (int i = 0; i < 40; i++) begin
         ctl = 3'($urandom % 4);
         wr(ocinrush_pkg::CTRL_OFF, {29'h0, ctl});
         @(posedge aclk);
         ps <= (i % 8 == 0) ? '0 : S'($urandom);
         gs <= S'($urandom);
         ss <= S'($urandom);
         bfa <= 1'($urandom);
         repeat (2) @(posedge aclk);
         #1;
         chkb(bps, |ps & !(bfa & ctl[0]));
         chkb(bgs, |ps & !(bfa & ctl[1]));
         chk({pso, gso, sso}, {ps, gs, ss});
      end
      for (int i = 0; i < 40; i++) begin
         thr = 8'(15 + $urandom % 6); // stays in the usual band
         lift = 16'(200 + $urandom % 2000);
         ctl = {1'($urandom), 2'h0};
         wr(ocinrush_pkg::CTRL_OFF, {29'h0, ctl});
         wr(ocinrush_pkg::THR_OFF, {24'h0, thr});
         wr(ocinrush_pkg::SEFTHR_OFF, {24'h0, thr + 8'h2});
         wr(ocinrush_pkg::LIFT_OFF, {16'h0, lift});
         {va, vb, vc, vs} = {rm(), rm(), rm(), rm()};
         case (i)
            0: {va, vs} = {16'h0032, 16'h0032, 16'h0032, 16'h0003, 16'h0003, 16'h0003};
            1: {va, vs} = {lift, lift, lift, 16'h0004, 16'h0004, 16'h0004};
            2: {va, vs} = {16'h0064, 8'h0, thr, 16'h0064, 16'h0064, 16'h0064, 16'h0709};
            3: vs = {16'h0064, 16'h0064, 16'h0708};
            default: ;
         endcase
         pulse(va, vb, vc, vs);
         {ea, eb, ec} = {hexp(va, thr, lift, 0), hexp(vb, thr, lift, 0), hexp(vc, thr, lift, 0)};
         es = hexp(vs, thr + 8'h2, lift, 1);
         chkb(ha, ea);
         chkb(hb, eb);
         chkb(hc, ec);
         chkb(hany, ea | eb | ec);
         chk({29'h0, pinh}, {29'h0, ctl[2] ? {3{ea | eb | ec}} : {ec, eb, ea}});
         chkb(hsef, es | sp);
         chk(ginh, {{2{ea | eb | ec}}, es | sp});
         sp = es;
      end
      wr(ocinrush_pkg::ELEM_OFF, 32'h0);
      pulse({16'h0064, 16'h0064, 16'h0064}, va, va, va);
      chk({26'h0, ginh, pinh}, 32'h0);
      ps <= 0;
      wr(ocinrush_pkg::MASK_OFF, 32'h1);
      wr(ocinrush_pkg::IRQ_OFF, 32'hF);
      @(posedge aclk);
      {ps, bfa, flt} <= {4'h1, 1'b0, 1'b1};
      repeat (30) @(posedge aclk);
      #1;
      chkb(irq, 1);
      chkb(utr, 0);
      chkb(btr, 0);
      @(posedge aclk);
      ps <= 0;
      repeat (30) @(posedge aclk);
      #1;
      chkb(utr, 1);
      chkb(btr, 1);
      wr(ocinrush_pkg::IRQ_OFF, 32'h1);
      rd(ocinrush_pkg::IRQ_OFF, d, r);
      chk(d & 32'h3, 32'h2);
      chkb(irq, 0);
      finish_test();
   end
endmodule  // tb_top
`default_nettype wire
